/* inc/dtms_defines.svh */
// timing and field constants for the termination mode sequencer
`ifndef DTMS_DEFINES_SVH
`define DTMS_DEFINES_SVH
`define DTMS_CLK_HZ        100000000
`define DTMS_PG_DELAY_US   10000
`define DTMS_OC_LIMIT_US   10000
`define DTMS_RETRY_US      100000
`define DTMS_SS_US         2000
`define DTMS_FILTER_US     20
`define DTMS_CNT_W         24
`define DTMS_RATE_W        4
`define DTMS_RATE_DEFAULT  4'h0
`define DTMS_RATE_STEPS    15
`define DTMS_RATE_MIN_KHZ  200
`define DTMS_RATE_MAX_KHZ  1000
`define DTMS_SYNC_IDLE     8'hc0
`endif

/* inc/dtms_pkg.sv */
// types for the termination mode sequencer
package dtms_pkg;
   typedef enum logic [7:0] {
      dtms_off_type_st   = 8'h01,
      dtms_bias_type_st  = 8'h02,
      dtms_soft_type_st  = 8'h04,
      dtms_delay_type_st = 8'h08,
      dtms_run_type_st   = 8'h10,
      dtms_limit_type_st = 8'h20,
      dtms_hot_type_st   = 8'h40,
      dtms_retry_type_st = 8'h80
   } dtms_state_type;
endpackage

/* src/dtms_sequencer.sv */
// control and supervisory sequencer for a ddr termination regulator
//
// Contract
// R1 - power good low only after successful start
// R2 - power good low 10 ms after start-up
// R3 - any fault releases power good
// R4 - normal mode needs supply, inputs high, no fault
// R5 - standby: output tri-stated, reference kept active
// R6 - shutdown: outputs off, discharged, bias off
// R7 - discharge switches enabled only in shutdown
// R8 - shutdown at power-on: nothing powers up
// R9 - standby at power-on: bias only, then wait
// R10 - on release: drop reset, enable, latch rate
// R11 - then run a soft-start ramp
// R12 - soft start on every exit and retry
// R13 - oscillator ticks; default rate 1.0 MHz
// R14 - accept monitor faults, command converter
// R15 - host drives mode inputs low to request
// R16 - host should supply rail before release
// R17 - 20 us filter on over/under voltage
// R18 - over-current 10 ms limit, then 100 ms retry
// R19 - short circuit: off at once, 100 ms retry
// R20 - thermal: off, clear, wait 100 ms, retry
// R21 - delays counted in latched-rate oscillator ticks
// R22 - leaving normal or fault restarts pg delay
`timescale 1ns/100ps
`include "dtms_defines.svh"

module dtms_sequencer
   import dtms_pkg::*;
(
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset_n,
   // host mode pins, asynchronous
   input  wire logic                     standby_n,
   input  wire logic                     shutdown_n,
   input  wire logic                     supply_in_range,
   input  wire logic [`DTMS_RATE_W-1:0]  switch_rate_setting,
   // protection monitors, asynchronous
   input  wire logic                     over_current,
   input  wire logic                     short_circuit,
   input  wire logic                     over_temp,
   input  wire logic                     out_of_window,
   input  wire logic                     in_regulation,
   // open-drain power good, enable high while pulling low
   output logic                          power_good_n_out,
   output logic                          power_good_n_oe,
   // converter and bias controls
   output logic                          internal_bias_enable,
   output logic                          power_on_reset_flag,
   output logic                          blocks_enable,
   output logic                          converter_enable,
   output logic                          soft_start_active,
   output logic                          termination_drive_enable,
   output logic                          reference_buffer_enable,
   output logic                          termination_discharge,
   output logic                          reference_discharge,
   output logic [`DTMS_RATE_W-1:0]       latched_rate,
   output logic                          osc_tick
);
   import dtms_pkg::*;

   // converts microseconds to oscillator ticks at the latched rate
   function automatic logic [`DTMS_CNT_W-1:0] us_to_ticks(input logic [`DTMS_RATE_W-1:0] r,
                                                          input int unsigned us);
      int unsigned khz;
      khz = `DTMS_RATE_MAX_KHZ
            - (int'(r) * (`DTMS_RATE_MAX_KHZ - `DTMS_RATE_MIN_KHZ)) / `DTMS_RATE_STEPS;
      return `DTMS_CNT_W'((us * khz) / 1000);
   endfunction

   // two-flop synchronisers for every pin input
   logic [7:0] sync_a;
   logic [7:0] sync_b;
   logic [7:0] next_sync_a;
   // rate pin gets its own pair; only the second stage is ever read
   logic [`DTMS_RATE_W-1:0] rate_sync_a;
   logic [`DTMS_RATE_W-1:0] rate_sync_b;
   logic [`DTMS_RATE_W-1:0] next_rate_sync_a;
   always_comb begin
      next_sync_a = {standby_n, shutdown_n, supply_in_range, over_current,
                     short_circuit, over_temp, out_of_window, in_regulation};
      // the rate code is a static strap; a change within two cycles of the
      // latch may be taken half old, so the host must set it before release
      next_rate_sync_a = switch_rate_setting;
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         // mode pins idle high, supply not ok: no false start after reset
         sync_a      <= `DTMS_SYNC_IDLE;
         sync_b      <= `DTMS_SYNC_IDLE;
         rate_sync_a <= `DTMS_RATE_DEFAULT;
         rate_sync_b <= `DTMS_RATE_DEFAULT;
      end else begin
         sync_a      <= next_sync_a;
         sync_b      <= sync_a;
         rate_sync_a <= next_rate_sync_a;
         rate_sync_b <= rate_sync_a;
      end
   end
   logic standby_n_req, sd_req, vin_ok, oc_s, sc_s, ot_s, win_s, reg_s;
   assign standby_n_req = !sync_b[7];
   assign sd_req   = !sync_b[6];
   assign vin_ok   = sync_b[5];
   assign oc_s     = sync_b[4];
   assign sc_s     = sync_b[3];
   assign ot_s     = sync_b[2];
   assign win_s    = sync_b[1];
   assign reg_s    = sync_b[0];

   // oscillator tick divider; period follows the latched rate
   logic [`DTMS_CNT_W-1:0] div_cnt, next_div_cnt;
   logic [`DTMS_RATE_W-1:0] rate, next_rate;
   logic tick, next_tick;
   logic [`DTMS_CNT_W-1:0] div_top;
   always_comb begin
      // clocks per oscillator tick: 100 MHz over the rate in kHz
      div_top = `DTMS_CNT_W'((`DTMS_CLK_HZ / 1000)
                / (`DTMS_RATE_MAX_KHZ - (int'(rate) * (`DTMS_RATE_MAX_KHZ
                   - `DTMS_RATE_MIN_KHZ)) / `DTMS_RATE_STEPS) - 1);
      // compare with >= so a faster new rate never lets the count run past
      next_tick    = (div_cnt >= div_top); // R13
      next_div_cnt = next_tick ? '0 : div_cnt + 1'b1;
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick    <= next_tick;
      end
   end

   // over/under voltage filter; a short glitch never reaches power good
   logic [`DTMS_CNT_W-1:0] flt_cnt, next_flt_cnt;
   logic win_fault, next_win_fault;
   always_comb begin
      next_flt_cnt   = flt_cnt;
      next_win_fault = win_fault;
      if (!win_s) begin
         next_flt_cnt   = '0;
         next_win_fault = 1'b0; // cleared at once, pg restarts its delay
      end else if (tick) begin
         if (flt_cnt >= us_to_ticks(rate, `DTMS_FILTER_US))
            next_win_fault = 1'b1; // R17
         else
            next_flt_cnt = flt_cnt + 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         flt_cnt   <= '0;
         win_fault <= 1'b0;
      end else begin
         flt_cnt   <= next_flt_cnt;
         win_fault <= next_win_fault;
      end
   end

   // main sequencer
   dtms_state_type state, next_state;
   logic [`DTMS_CNT_W-1:0] tmr, next_tmr;
   logic mode_ok;
   always_comb begin
      mode_ok       = vin_ok && !standby_n_req && !sd_req; // R4
      next_state    = state;
      next_tmr      = tmr;
      next_rate     = rate;
      case (state)
         dtms_off_type_st: begin
            // shutdown holds everything down, bias included
            next_tmr = '0;
            if (vin_ok && !sd_req)
               next_state = dtms_bias_type_st; // R8
         end
         dtms_bias_type_st: begin
            next_tmr = '0;
            if (sd_req || !vin_ok)
               next_state = dtms_off_type_st;
            else if (!standby_n_req) begin
               next_rate  = rate_sync_b; // R10
               next_state = dtms_soft_type_st; // R9 R11
            end
         end
         dtms_soft_type_st, dtms_delay_type_st, dtms_run_type_st,
         dtms_limit_type_st: begin
            if (!mode_ok)
               next_state = sd_req || !vin_ok ? dtms_off_type_st
                                                : dtms_bias_type_st; // R22
            else if (ot_s) begin
               next_state = dtms_hot_type_st; // R20 R14
            end else if (sc_s) begin
               next_tmr   = '0;
               next_state = dtms_retry_type_st; // R19
            end else if (state == dtms_soft_type_st) begin
               if (tick)
                  next_tmr = tmr + 1'b1;
               if (reg_s || tmr >= us_to_ticks(rate, `DTMS_SS_US)) begin
                  next_tmr   = '0;
                  next_state = dtms_delay_type_st;
               end
            end else if (oc_s && state != dtms_limit_type_st) begin
               next_tmr   = '0;
               next_state = dtms_limit_type_st; // R18
            end else if (state == dtms_limit_type_st) begin
               if (!oc_s) begin
                  next_tmr   = '0;
                  next_state = dtms_delay_type_st;
               end else if (tick) begin
                  next_tmr = tmr + 1'b1;
                  if (tmr >= us_to_ticks(rate, `DTMS_OC_LIMIT_US)) begin
                     next_tmr   = '0;
                     next_state = dtms_retry_type_st; // R18
                  end
               end
            end else if (win_fault || !reg_s) begin
               next_tmr   = '0;
               next_state = dtms_delay_type_st; // R22 R3
            end else if (state == dtms_delay_type_st) begin
               if (tick)
                  next_tmr = tmr + 1'b1;
               if (tmr >= us_to_ticks(rate, `DTMS_PG_DELAY_US))
                  next_state = dtms_run_type_st; // R2 R21
            end
         end
         dtms_hot_type_st: begin
            // retry timer only runs once the temperature has dropped
            next_tmr   = '0;
            next_state = !mode_ok ? dtms_off_type_st
                       : (!ot_s ? dtms_retry_type_st : dtms_hot_type_st); // R20
         end
         dtms_retry_type_st: begin
            if (!mode_ok)
               next_state = dtms_off_type_st;
            else if (ot_s)
               next_state = dtms_hot_type_st;
            else if (tick) begin
               next_tmr = tmr + 1'b1;
               if (tmr >= us_to_ticks(rate, `DTMS_RETRY_US)) begin
                  next_tmr   = '0;
                  next_state = dtms_soft_type_st; // R12
               end
            end
         end
         default: next_state = dtms_off_type_st;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state    <= dtms_off_type_st;
         tmr      <= '0;
         rate     <= `DTMS_RATE_DEFAULT;
      end else begin
         state    <= next_state;
         tmr      <= next_tmr;
         rate     <= next_rate;
      end
   end

   // registered outputs decoded from the next state
   logic active, pg_on;
   always_comb begin
      active = next_state inside {dtms_soft_type_st, dtms_delay_type_st,
                                 dtms_run_type_st, dtms_limit_type_st};
      pg_on  = (next_state == dtms_run_type_st) && !win_fault; // R1 R3
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         power_good_n_oe          <= 1'b0;
         internal_bias_enable     <= 1'b0;
         power_on_reset_flag      <= 1'b1;
         blocks_enable            <= 1'b0;
         converter_enable         <= 1'b0;
         soft_start_active        <= 1'b0;
         termination_drive_enable <= 1'b0;
         reference_buffer_enable  <= 1'b0;
         termination_discharge    <= 1'b0;
         reference_discharge      <= 1'b0;
      end else begin
         power_good_n_oe          <= pg_on; // R1
         internal_bias_enable     <= next_state != dtms_off_type_st; // R6 R9
         power_on_reset_flag      <= !(active || next_state == dtms_retry_type_st
                                       || next_state == dtms_hot_type_st); // R10
         blocks_enable            <= next_state != dtms_off_type_st
                                     && next_state != dtms_bias_type_st; // R5
         converter_enable         <= active; // R14
         soft_start_active        <= next_state == dtms_soft_type_st; // R11
         termination_drive_enable <= active; // R5
         reference_buffer_enable  <= next_state != dtms_off_type_st; // R5
         termination_discharge    <= next_state == dtms_off_type_st && sd_req; // R7
         reference_discharge      <= next_state == dtms_off_type_st && sd_req; // R6
      end
   end
   assign power_good_n_out = 1'b0;
   assign latched_rate     = rate;
   assign osc_tick         = tick;
endmodule // dtms_sequencer

/* tb/dtms_checker.sv */
// assertion checker for the termination mode sequencer
`timescale 1ns/100ps
`include "dtms_defines.svh"
module dtms_checker (
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    reset_n,
   // host and monitor inputs
   input wire logic                    standby_n,
   input wire logic                    shutdown_n,
   input wire logic [`DTMS_RATE_W-1:0] switch_rate_setting,
   input wire logic                    short_circuit,
   input wire logic                    over_temp,
   // sequencer outputs
   input wire logic                    power_good_n_oe,
   input wire logic                    internal_bias_enable,
   input wire logic                    power_on_reset_flag,
   input wire logic                    blocks_enable,
   input wire logic                    converter_enable,
   input wire logic                    soft_start_active,
   input wire logic                    termination_drive_enable,
   input wire logic                    termination_discharge,
   input wire logic                    reference_discharge,
   input wire logic [`DTMS_RATE_W-1:0] latched_rate,
   input wire logic                    osc_tick
);
   // one domain, so clock and reset are given once
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // repetitions of five, and four for the short, cover the two sync flops plus the state edge
   property p_disc;
      termination_discharge |-> !converter_enable && !termination_drive_enable;
   endproperty
   a_disc: assert property (p_disc) else $error("discharge while converting");
   property p_hot; over_temp [*5] |-> !power_good_n_oe && !converter_enable; endproperty
   a_hot: assert property (p_hot) else $error("thermal fault not acted on");
   property p_pg; power_good_n_oe |-> converter_enable && !soft_start_active; endproperty
   a_pg: assert property (p_pg) else $error("power good outside run");
   property p_sd;
      !shutdown_n [*5] |-> !internal_bias_enable && !converter_enable
         && termination_discharge && reference_discharge;
   endproperty
   a_sd: assert property (p_sd) else $error("shutdown outputs wrong");
   property p_sby;
      (!standby_n && shutdown_n) [*5] |-> !converter_enable && !termination_drive_enable;
   endproperty
   a_sby: assert property (p_sby) else $error("standby still driving");
   property p_up;
      $rose(soft_start_active) |-> blocks_enable && converter_enable && !power_on_reset_flag;
   endproperty
   a_up: assert property (p_up) else $error("ramp without blocks up");
   // the rate pin passes two sync flops before the latch edge
   property p_rate;
      $rose(soft_start_active) |-> latched_rate == $past(switch_rate_setting, 3);
   endproperty
   a_rate: assert property (p_rate) else $error("rate not latched");
   property p_hold; !$rose(soft_start_active) |-> $stable(latched_rate); endproperty
   a_hold: assert property (p_hold) else $error("rate changed outside latch");
   property p_short; short_circuit [*4] |-> !converter_enable; endproperty
   a_short: assert property (p_short) else $error("short not shut down");
   property p_tick; osc_tick |=> !osc_tick [*8]; endproperty
   a_tick: assert property (p_tick) else $error("tick period too short");
endmodule // dtms_checker
bind dtms_sequencer dtms_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .standby_n(standby_n), .shutdown_n(shutdown_n), .switch_rate_setting(switch_rate_setting),
   .short_circuit(short_circuit), .over_temp(over_temp), .power_good_n_oe(power_good_n_oe),
   .internal_bias_enable(internal_bias_enable), .power_on_reset_flag(power_on_reset_flag),
   .blocks_enable(blocks_enable), .converter_enable(converter_enable),
   .soft_start_active(soft_start_active), .termination_drive_enable(termination_drive_enable),
   .termination_discharge(termination_discharge), .reference_discharge(reference_discharge),
   .latched_rate(latched_rate), .osc_tick(osc_tick));

/* tb/dtms_host_model.sv */
// host power manager model driving the mode pins
`timescale 1ns/100ps
module dtms_host_model (
   // requests from the bench
   input wire logic want_standby,
   input wire logic want_shutdown,
   // open-drain power good from the sequencer
   input wire logic power_good_n_out,
   input wire logic power_good_n_oe,
   // mode pins and the resolved power good line
   output logic     standby_n,
   output logic     shutdown_n,
   output logic     pg_line
);
   // a request pulls its pin low, else the pin is released high
   assign standby_n  = !want_standby;
   assign shutdown_n = !want_shutdown;
   // the rail is taken as present before any release is made
   // pull-up wins whenever the sequencer lets go of the line
   assign pg_line = power_good_n_oe ? power_good_n_out : 1'b1;
endmodule // dtms_host_model

/* tb/dtms_sequencer_bench.sv */
// self-checking bench for the termination mode sequencer
`timescale 1ns/100ps
module dtms_sequencer_bench;
   // stimulus, driven at the falling edge
   logic       ref_clk = 1'b0, reset_n = 1'b0, want_standby = 1'b0, want_shutdown = 1'b1;
   logic [3:0] rate = 4'h5;
   logic       oc = 1'b0, sc = 1'b0, ot = 1'b0, oow = 1'b0, inreg = 1'b0, vin = 1'b1;
   // observed outputs
   logic       standby_n, shutdown_n, pg_line, pg_out, pg_oe, bias, por, blk, conv, ss;
   logic       tdrv, rbuf, tdis, rdis, tick;
   logic [3:0] lrate;
   int         bad_count = 0, samples_checked = 0, cycles = 0;
   always #5 ref_clk = ~ref_clk;
   dtms_host_model host (.want_standby(want_standby), .want_shutdown(want_shutdown),
      .power_good_n_out(pg_out), .power_good_n_oe(pg_oe), .standby_n(standby_n),
      .shutdown_n(shutdown_n), .pg_line(pg_line));
   dtms_sequencer DUT (.ref_clk(ref_clk), .reset_n(reset_n), .standby_n(standby_n),
      .shutdown_n(shutdown_n), .supply_in_range(vin), .switch_rate_setting(rate),
      .over_current(oc), .short_circuit(sc), .over_temp(ot), .out_of_window(oow),
      .in_regulation(inreg), .power_good_n_out(pg_out), .power_good_n_oe(pg_oe),
      .internal_bias_enable(bias), .power_on_reset_flag(por), .blocks_enable(blk),
      .converter_enable(conv), .soft_start_active(ss), .termination_drive_enable(tdrv),
      .reference_buffer_enable(rbuf), .termination_discharge(tdis),
      .reference_discharge(rdis), .latched_rate(lrate), .osc_tick(tick));
   task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait for a ramp to begin
   task automatic wait_soft();
      int k;
      k = 0;
      while (ss !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      chk("soft_start", ss, 1'b1);
   endtask
   task automatic t_standby_bias();
      want_standby = 1'b1;
      want_shutdown = 1'b0;
      cyc(6);
      chk("bias", bias, 1'b1);
      chk("blocks", blk, 1'b0);
      chk("conv", conv, 1'b0);
      chk("tdis", tdis, 1'b0);
   endtask
   task automatic t_release();
      want_standby = 1'b0;
      wait_soft();
      chk("por", por, 1'b0);
      chk("blocks", blk, 1'b1);
      chk("conv", conv, 1'b1);
      chk("lrate", lrate, 4'h5);
      rate = 4'hf;
      cyc(5);
      chk("lrate held", lrate, 4'h5);
   endtask
   // brief limit and a filtered window fault keep the outputs running
   task automatic t_light_faults();
      inreg = 1'b1;
      oc = 1'b1;
      cyc(50);
      oc = 1'b0;
      chk("conv oc", conv, 1'b1);
      oow = 1'b1;
      cyc(2500);
      chk("conv oow", conv, 1'b1);
      chk("pg oow", pg_line, 1'b1);
      oow = 1'b0;
      cyc(10);
      chk("pg restart", pg_line, 1'b1);
   endtask
   task automatic t_standby_mode();
      want_standby = 1'b1;
      cyc(6);
      chk("tdrv", tdrv, 1'b0);
      chk("rbuf", rbuf, 1'b1);
      chk("tdis", tdis, 1'b0);
      want_standby = 1'b0;
      wait_soft();
      chk("lrate sby", lrate, 4'hf);
   endtask
   task automatic t_thermal();
      ot = 1'b1;
      cyc(6);
      chk("pg hot", pg_line, 1'b1);
      chk("conv hot", conv, 1'b0);
      ot = 1'b0;
      cyc(1000);
      chk("conv wait", conv, 1'b0);
   endtask
   task automatic t_shutdown();
      want_shutdown = 1'b1;
      cyc(6);
      chk("tdis", tdis, 1'b1);
      chk("rdis", rdis, 1'b1);
      chk("bias", bias, 1'b0);
      rate = 4'h0;
      want_shutdown = 1'b0;
      wait_soft();
      chk("lrate new", lrate, 4'h0);
   endtask
   // supply loss drops to off without discharge; its return restarts the ramp
   task automatic t_supply();
      vin = 1'b0;
      cyc(6);
      chk("conv vin", conv, 1'b0);
      chk("bias vin", bias, 1'b0);
      chk("tdis vin", tdis, 1'b0);
      vin = 1'b1;
      wait_soft();
   endtask
   task automatic t_short();
      sc = 1'b1;
      cyc(6);
      chk("conv sc", conv, 1'b0);
      sc = 1'b0;
      cyc(500);
      chk("no early retry", ss, 1'b0);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      cyc(6);
      chk("por rst", por, 1'b1);
      reset_n = 1'b1;
      cyc(8);
      chk("bias sd", bias, 1'b0);
      chk("conv sd", conv, 1'b0);
      t_standby_bias();
      t_release();
      t_light_faults();
      t_standby_mode();
      t_thermal();
      t_shutdown();
      t_short();
      t_supply();
      close_out();
   end
endmodule // dtms_sequencer_bench
